// ---- verilog/psq_top.sv ----
// Pattern bit sequencer with capture/stimulus data path and AHB-Lite registers
// Operation
// RL1: Clock divider, address counter and 256K by 16 pattern memory, one word per step.
// RL2: Low eight word bits drive free user channels.
// RL3: High eight word bits are dedicated internal strobes and enables.
// RL4: Word bit 8 does nothing.
// RL5: Rising bit 9 shifts the serial register one place.
// RL6: Outside pattern must make a serial device clock on a user channel.
// RL7: Rising bit 10 stores parallel input or shift register contents.
// RL8: Capture strobe stores latest result and starts next conversion.
// RL9: Each capture strobe advances the capture address by one.
// RL10: Bit 11 is the stimulus strobe and drives the fast output line.
// RL11: Bit 12 high turns off all data outputs.
// RL12: Bit 13 high turns off the eight user outputs.
// RL13: Bit 14 is upper byte enable or upper byte strobe.
// RL14: Bit 15 is lower byte enable or lower byte strobe.
// RL15: Captured data is ANDed with the programmable mask.
// RL16: Direction/format 0,0 means parallel input.
// RL17: Capture address reloads return pointer at end address.
// RL18: Capture address holds while latency count is nonzero.
// RL19: Settle loops count samples without storing.
// RL20: Measure count reaching zero releases the ready line.
// RL21: Each step drives the current word and advances the pattern address.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
module psq_top
   import psq_pkg::*;
(
   // AHB-Lite slave
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // User channels
   output logic      [7:0]                  user_bits,
   output logic      [7:0]                  user_bits_oe,
   // Data port
   input  wire logic [psq_pkg::WORD_W-1:0]  data_in,
   output logic      [psq_pkg::WORD_W-1:0]  data_out,
   output logic      [psq_pkg::WORD_W-1:0]  data_oe,
   input  wire logic                        serial_in,
   // Fast lines and ready
   input  wire logic                        fast_input_line,
   output logic                             fast_output_line,
   output logic                             conversion_start,
   output logic                             ready_out,
   output logic                             ready_oe
);
   import psq_pkg::*;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic [7:0]        ofs_q;
   logic              wr_q;
   logic              rd_q;
   logic              ctrl_run_q;
   logic              ctrl_ser_q;
   logic              ctrl_fast_q;
   logic [DIV_W-1:0]  clkdiv_q;
   logic [ADDR_W-1:0] pat_start_q, pat_ret_q, pat_end_q, pat_waddr_q;
   logic [WORD_W-1:0] mask_q, stim_data_q;
   logic [1:0]        iomode_q;
   logic [ADDR_W-1:0] cap_pre_q, cap_ret_q, cap_end_q, cap_raddr_q;
   logic [LOOP_W-1:0] settle_set_q, meas_set_q, lat_set_q;

   wire        bus_take = hsel & hready & htrans[1];
   wire        wr_en    = wr_q;
   wire        start    = wr_en & (ofs_q == OFS_CTRL) & hwdata[CTRL_RUN];
   wire        pat_wr   = wr_en & (ofs_q == OFS_PAT_WDATA);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ofs_q <= 8'h00;
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
      end else begin
         ofs_q <= haddr[7:0];
         wr_q  <= bus_take & hwrite;
         rd_q  <= bus_take & ~hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_run_q   <= 1'b0;
         ctrl_ser_q   <= 1'b0;
         ctrl_fast_q  <= 1'b0;
         clkdiv_q     <= RST_CLKDIV;
         pat_start_q  <= '0;
         pat_ret_q    <= '0;
         pat_end_q    <= '0;
         pat_waddr_q  <= '0;
         mask_q       <= RST_MASK;
         iomode_q     <= RST_IOMODE;
         cap_pre_q    <= '0;
         cap_ret_q    <= '0;
         cap_end_q    <= '0;
         settle_set_q <= '0;
         meas_set_q   <= '0;
         lat_set_q    <= '0;
         stim_data_q  <= '0;
         cap_raddr_q  <= '0;
      end else if (wr_en) begin
         case (ofs_q)
            OFS_CTRL: begin
               ctrl_run_q  <= hwdata[CTRL_RUN];
               ctrl_ser_q  <= hwdata[CTRL_SERIAL];
               ctrl_fast_q <= hwdata[CTRL_FAST_IN];
            end
            OFS_CLKDIV:    clkdiv_q     <= hwdata[DIV_W-1:0];
            OFS_PAT_START: pat_start_q  <= hwdata[ADDR_W-1:0];
            OFS_PAT_RET:   pat_ret_q    <= hwdata[ADDR_W-1:0];
            OFS_PAT_END:   pat_end_q    <= hwdata[ADDR_W-1:0];
            OFS_PAT_WADDR: pat_waddr_q  <= hwdata[ADDR_W-1:0];
            OFS_PAT_WDATA: pat_waddr_q  <= pat_waddr_q + 1'b1;
            OFS_MASK:      mask_q       <= hwdata[WORD_W-1:0];
            OFS_IOMODE:    iomode_q     <= hwdata[1:0];
            OFS_CAP_PRE:   cap_pre_q    <= hwdata[ADDR_W-1:0];
            OFS_CAP_RET:   cap_ret_q    <= hwdata[ADDR_W-1:0];
            OFS_CAP_END:   cap_end_q    <= hwdata[ADDR_W-1:0];
            OFS_SETTLE:    settle_set_q <= hwdata[LOOP_W-1:0];
            OFS_MEASURE:   meas_set_q   <= hwdata[LOOP_W-1:0];
            OFS_LATENCY:   lat_set_q    <= hwdata[LOOP_W-1:0];
            OFS_STIM_DATA: stim_data_q  <= hwdata[WORD_W-1:0];
            OFS_CAP_RADDR: cap_raddr_q  <= hwdata[ADDR_W-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pattern generator
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] pat_mem [0:PAT_DEPTH-1];                         // [RL1]
   logic [ADDR_W-1:0] pat_addr_q;
   logic [DIV_W-1:0]  div_cnt_q;
   logic [WORD_W-1:0] word_q;
   logic [WORD_W-1:0] word_prev_q;

   // A divider value of zero runs like one, so the step never stalls
   wire div_last = (div_cnt_q + 1'b1 >= clkdiv_q);                     // [RL1]
   wire step     = ctrl_run_q & ~start & div_last;
   wire [ADDR_W-1:0] pat_next = (pat_addr_q == pat_end_q) ? pat_ret_q
                                                         : pat_addr_q + 1'b1;

   always_ff @(posedge hclk) begin
      if (pat_wr)
         pat_mem[pat_waddr_q] <= hwdata[WORD_W-1:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pat_addr_q  <= '0;
         div_cnt_q   <= '0;
         word_q      <= RST_WORD;
         word_prev_q <= RST_WORD;
      end else begin
         word_prev_q <= word_q;
         if (start) begin
            pat_addr_q <= pat_start_q;
            div_cnt_q  <= '0;
         end else if (step) begin
            word_q     <= pat_mem[pat_addr_q];                         // [RL21]
            pat_addr_q <= pat_next;                                    // [RL21]
            div_cnt_q  <= '0;
         end else if (ctrl_run_q) begin
            div_cnt_q  <= div_cnt_q + 1'b1;
         end
      end
   end

   // Dedicated channel edges; bit 8 is deliberately left unread  [RL3] [RL4]
   wire [WORD_W-1:0] rise = word_q & ~word_prev_q;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [WORD_W+1:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {fast_input_line, serial_in, data_in};
         pin_s2_q <= pin_s1_q;
      end
   end
   wire [WORD_W-1:0] din_s   = pin_s2_q[WORD_W-1:0];
   wire              ser_s   = pin_s2_q[WORD_W];
   logic             fast_prev_q;
   wire              fast_rise = pin_s2_q[WORD_W+1] & ~fast_prev_q;

   // ----------------------------------------------------------------
   // Input data path
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] shift_q, in_reg_q;
   wire byte_mode  = iomode_q[IOM_BYTEWISE];
   wire out_mode   = iomode_q[IOM_OUTPUT];
   wire par_in     = (iomode_q == 2'h0);                               // [RL16]
   wire cap_strobe = ctrl_fast_q ? fast_rise : rise[BIT_CAPTURE];
   wire [WORD_W-1:0] cap_src  = ctrl_ser_q ? shift_q : in_reg_q;       // [RL7]
   wire [WORD_W-1:0] cap_data = cap_src & mask_q;                      // [RL15]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_q     <= '0;
         in_reg_q    <= '0;
         fast_prev_q <= 1'b0;
      end else begin
         fast_prev_q <= pin_s2_q[WORD_W+1];
         if (rise[BIT_SHIFT])
            shift_q <= {shift_q[WORD_W-2:0], ser_s};                   // [RL5]
         if (par_in)
            in_reg_q <= din_s;                                         // [RL16]
         else if (!out_mode && byte_mode) begin
            if (rise[BIT_UPPER])
               in_reg_q[15:8] <= din_s[7:0];                           // [RL13]
            if (rise[BIT_LOWER])
               in_reg_q[7:0]  <= din_s[7:0];                           // [RL14]
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture counters and memory
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] cap_mem [0:PAT_DEPTH-1];
   logic [ADDR_W-1:0] cap_addr_q;
   logic [LOOP_W-1:0] lat_q, settle_q, meas_q;
   logic [WORD_W-1:0] cap_rd_q;
   logic              armed_q;

   wire cap_active = armed_q & (meas_q != '0) & cap_strobe;
   wire lat_hold   = lat_q != '0;                                      // [RL18]
   wire settling   = settle_q != '0;
   wire at_end     = cap_addr_q == cap_end_q;
   wire cap_write  = cap_active & ~lat_hold & ~settling;               // [RL19]
   wire [ADDR_W-1:0] cap_next = at_end ? cap_ret_q : cap_addr_q + 1'b1; // [RL17]

   always_ff @(posedge hclk) begin
      if (cap_write)
         cap_mem[cap_addr_q] <= cap_data;                              // [RL7]
      cap_rd_q <= cap_mem[cap_raddr_q];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_addr_q <= '0;
         lat_q      <= '0;
         settle_q   <= '0;
         meas_q     <= '0;
         armed_q    <= 1'b0;
      end else if (start) begin
         cap_addr_q <= cap_pre_q;
         lat_q      <= lat_set_q;
         settle_q   <= settle_set_q;
         meas_q     <= meas_set_q;
         armed_q    <= 1'b1;
      end else if (cap_active) begin
         if (lat_hold)
            lat_q <= lat_q - 1'b1;                                     // [RL18]
         else begin
            cap_addr_q <= cap_next;                                    // [RL9]
            if (at_end && settling)
               settle_q <= settle_q - 1'b1;                            // [RL19]
            else if (at_end)
               meas_q <= meas_q - 1'b1;                                // [RL20]
         end
      end
   end

   // Ready is open collector: held low only while measurement loops remain
   assign ready_out = 1'b0;
   assign ready_oe  = armed_q & (meas_q != '0);                        // [RL20]
   // One conversion is launched per accepted strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         conversion_start <= 1'b0;
      else
         conversion_start <= cap_active;                               // [RL8]
   end

   // ----------------------------------------------------------------
   // Output data path
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         data_out <= '0;
      else if (out_mode && !byte_mode && rise[BIT_STIMULUS])
         data_out <= stim_data_q;                                      // [RL10]
      else if (out_mode && byte_mode && rise[BIT_UPPER])
         data_out[7:0] <= stim_data_q[15:8];                           // [RL13]
      else if (out_mode && byte_mode && rise[BIT_LOWER])
         data_out[7:0] <= stim_data_q[7:0];                            // [RL14]
   end

   // Enables are active low in the word and ORed with the global one
   wire hb_on = out_mode & ~word_q[BIT_DATA_OE_N] & ~byte_mode & ~word_q[BIT_UPPER]; // [RL13]
   wire lb_on = out_mode & ~word_q[BIT_DATA_OE_N] & (byte_mode | ~word_q[BIT_LOWER]); // [RL14]
   assign data_oe          = {{8{hb_on}}, {8{lb_on}}};                 // [RL11]
   assign user_bits        = word_q[7:0];                              // [RL2]
   assign user_bits_oe     = {8{~word_q[BIT_USER_OE_N]}};              // [RL12]
   assign fast_output_line = word_q[BIT_STIMULUS];                     // [RL10]

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   wire [31:0] status_w = {30'h0, ~ready_oe & armed_q, ctrl_run_q};
   always_comb begin
      hrdata = 32'h0;
      if (rd_q) begin
         case (ofs_q)
            OFS_CTRL:      hrdata = {29'h0, ctrl_fast_q, ctrl_ser_q, ctrl_run_q};
            OFS_STATUS:    hrdata = status_w;
            OFS_PAT_ADDR:  hrdata = {14'h0, pat_addr_q};
            OFS_CAP_ADDR:  hrdata = {14'h0, cap_addr_q};
            OFS_CLKDIV:    hrdata = {8'h0, clkdiv_q};
            OFS_MASK:      hrdata = {16'h0, mask_q};
            OFS_IOMODE:    hrdata = {30'h0, iomode_q};
            OFS_SETTLE:    hrdata = {16'h0, settle_q};
            OFS_MEASURE:   hrdata = {16'h0, meas_q};
            OFS_LATENCY:   hrdata = {16'h0, lat_q};
            OFS_CAP_RDATA: hrdata = {16'h0, cap_rd_q};
            default:       hrdata = 32'h0;
         endcase
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   step_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)   // [RL21]
      step |=> word_q == $past(pat_mem[pat_addr_q]))
      else $error("step did not drive the addressed word");
   pat_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)     // [RL21]
      step && pat_addr_q == pat_end_q |=> pat_addr_q == $past(pat_ret_q))
      else $error("pattern address did not wrap");
   shift_one_a: assert property (@(posedge hclk) disable iff (!hresetn)    // [RL5]
      rise[BIT_SHIFT] |=> shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]))
      else $error("shift register did not move one place");
   latency_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RL18]
      cap_active && lat_hold && !start |=> $stable(cap_addr_q) && lat_q == $past(lat_q) - 1)
      else $error("address moved during latency");
   capture_adv_a: assert property (@(posedge hclk) disable iff (!hresetn)  // [RL9]
      cap_active && !lat_hold && !at_end && !start |=> cap_addr_q == $past(cap_addr_q) + 1)
      else $error("capture address did not advance");
   settle_nowr_a: assert property (@(posedge hclk) disable iff (!hresetn)  // [RL19]
      cap_active && settling |=> cap_mem[$past(cap_addr_q)] == $past(cap_mem[cap_addr_q]))
      else $error("data stored during settle loop");
   mask_and_a: assert property (@(posedge hclk) disable iff (!hresetn)     // [RL15]
      cap_write |=> cap_mem[$past(cap_addr_q)] == ($past(cap_src) & $past(mask_q)))
      else $error("mask not applied");
   ready_rel_a: assert property (@(posedge hclk) disable iff (!hresetn)    // [RL20]
      cap_active && !lat_hold && !settling && at_end && meas_q == 1 && !start
      |=> !ready_oe)
      else $error("ready not released at end");
   user_oe_a: assert property (@(posedge hclk) disable iff (!hresetn)      // [RL12]
      word_q[BIT_USER_OE_N] |-> user_bits_oe == 8'h00 ##1 1'b1)
      else $error("user outputs driven while disabled");
endmodule : psq_top

// ---- include/psq_pkg.sv ----
// Constants shared by the pattern bit sequencer
package psq_pkg;
   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int unsigned PAT_DEPTH = 262144;
   localparam int unsigned ADDR_W    = 18;
   localparam int unsigned WORD_W    = 16;
   localparam int unsigned DIV_W     = 24;
   localparam int unsigned LOOP_W    = 16;
   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_PAT_ADDR  = 8'h08;
   localparam logic [7:0] OFS_CAP_ADDR  = 8'h0C;
   localparam logic [7:0] OFS_CLKDIV    = 8'h10;
   localparam logic [7:0] OFS_PAT_START = 8'h14;
   localparam logic [7:0] OFS_PAT_RET   = 8'h18;
   localparam logic [7:0] OFS_PAT_END   = 8'h1C;
   localparam logic [7:0] OFS_PAT_WADDR = 8'h20;
   localparam logic [7:0] OFS_PAT_WDATA = 8'h24;
   localparam logic [7:0] OFS_MASK      = 8'h28;
   localparam logic [7:0] OFS_IOMODE    = 8'h2C;
   localparam logic [7:0] OFS_CAP_PRE   = 8'h30;
   localparam logic [7:0] OFS_CAP_RET   = 8'h34;
   localparam logic [7:0] OFS_CAP_END   = 8'h38;
   localparam logic [7:0] OFS_SETTLE    = 8'h3C;
   localparam logic [7:0] OFS_MEASURE   = 8'h40;
   localparam logic [7:0] OFS_LATENCY   = 8'h44;
   localparam logic [7:0] OFS_STIM_DATA = 8'h48;
   localparam logic [7:0] OFS_CAP_RADDR = 8'h4C;
   localparam logic [7:0] OFS_CAP_RDATA = 8'h50;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned CTRL_RUN      = 0;
   localparam int unsigned CTRL_SERIAL   = 1;
   localparam int unsigned CTRL_FAST_IN  = 2;
   localparam int unsigned IOM_OUTPUT    = 0;
   localparam int unsigned IOM_BYTEWISE  = 1;
   localparam int unsigned BIT_RESERVED  = 8;
   localparam int unsigned BIT_SHIFT     = 9;
   localparam int unsigned BIT_CAPTURE   = 10;
   localparam int unsigned BIT_STIMULUS  = 11;
   localparam int unsigned BIT_DATA_OE_N = 12;
   localparam int unsigned BIT_USER_OE_N = 13;
   localparam int unsigned BIT_UPPER     = 14;
   localparam int unsigned BIT_LOWER     = 15;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [WORD_W-1:0] RST_MASK   = 16'hFFFF;
   localparam logic [1:0]        RST_IOMODE = 2'h0;
   localparam logic [DIV_W-1:0]  RST_CLKDIV = 24'h000001;
   // Idle word: every enable high, so all drivers are off
   localparam logic [WORD_W-1:0] RST_WORD   = 16'hF000;
endpackage : psq_pkg

// ---- sim/psq_dut_model.sv ----
// Behavioural converter that answers the sequencer's user channels
module psq_dut_model
(
   // Clock and user channels
   input  wire logic        hclk,
   input  wire logic [7:0]  user_bits,
   input  wire logic [7:0]  user_bits_oe,
   // Converter outputs
   output logic      [15:0] data_in,
   output logic             serial_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q  = 8'h00;
   logic [7:0] sh_q   = 8'h00;
   logic [1:0] last_q = 2'h0;
   // A new result appears on each driven rise of user channel 0
   always @(posedge hclk) begin
      last_q <= user_bits[1:0] & user_bits_oe[1:0];
      if (user_bits_oe[0] && user_bits[0] && !last_q[0]) begin
         cnt_q <= cnt_q + 8'h01;
         sh_q  <= cnt_q + 8'h01;
      end else if (user_bits_oe[1] && user_bits[1] && !last_q[1]) begin
         sh_q <= {sh_q[6:0], 1'b0};
      end
   end
   // Upper byte is junk so that the input mask has work to do
   assign data_in   = {cnt_q ^ 8'h5A, cnt_q};
   assign serial_in = sh_q[7];
endmodule : psq_dut_model

// ---- sim/psq_top_tb.sv ----
// Self-checking bench for the pattern bit sequencer
module psq_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import psq_pkg::*;
   logic        hclk;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic [7:0]  user_bits;
   logic [7:0]  user_bits_oe;
   logic [15:0] data_in;
   logic [15:0] data_out;
   logic [15:0] data_oe;
   logic        serial_in;
   logic        fast_output_line;
   logic        conversion_start;
   logic        hresp;
   logic        ready_out;
   logic        ready_oe;
   int          failures    = 0;
   int          checks_done = 0;
   int          cyc         = 0;
   int          conv_n      = 0;
   logic [31:0] seed        = 32'hDCB2E36C;
   logic [31:0] rd;
   logic [15:0] mem_m [8];

   psq_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .user_bits(user_bits),
      .user_bits_oe(user_bits_oe), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .serial_in(serial_in), .fast_input_line(1'b0),
      .fast_output_line(fast_output_line), .conversion_start(conversion_start),
      .ready_out(ready_out), .ready_oe(ready_oe));
   psq_dut_model u_conv (.hclk(hclk), .user_bits(user_bits), .user_bits_oe(user_bits_oe),
      .data_in(data_in), .serial_in(serial_in));

   // -----------------------------------------------------------------
   // Clock, watchdog and helpers
   // -----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (conversion_start === 1'b1) conv_n <= conv_n + 1;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         close_out();
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One single AHB-Lite transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic close_out();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      int a;
      int n;
      int lat;
      int stl;
      int mea;
      int base;
      int exp_q[$];
      logic [31:0] r;
      logic [15:0] eo;
      logic [7:0]  wa [12] = '{OFS_IOMODE, OFS_MASK, OFS_CLKDIV, OFS_PAT_START, OFS_PAT_RET,
         OFS_PAT_END, OFS_CAP_PRE, OFS_CAP_RET, OFS_CAP_END, OFS_LATENCY, OFS_SETTLE,
         OFS_MEASURE};
      logic [7:0]  wv [12] = '{8'h00, 8'hFF, 8'h04, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h03,
         8'h02, 8'h01, 8'h01};
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk("user_oe", {24'h0, user_bits_oe}, 32'h0);
      chk("data_oe", {16'h0, data_oe}, 32'h0);
      bus(1'b0, OFS_MASK, 32'h0);
      chk("mask", rd, 32'h0000FFFF);
      bus(1'b0, 8'h7C, 32'h0);
      chk("unmapped", rd, 32'h0);
      // Random words, channel 0 kept low; word 0 carries a unique low byte
      for (int i = 0; i < 6; i++) begin
         r = xs();
         mem_m[i] = (i == 0) ? {r[15:8], 8'hFE} : (r[15:0] & 16'hFF7E);
      end
      mem_m[2][11] = 1'b0;
      mem_m[3][11] = 1'b1;
      bus(1'b1, OFS_IOMODE, 32'h1);
      bus(1'b1, OFS_STIM_DATA, 32'hA55A);
      bus(1'b1, OFS_CLKDIV, 32'h1);
      bus(1'b1, OFS_PAT_START, 32'h0);
      bus(1'b1, OFS_PAT_RET, 32'h2);
      bus(1'b1, OFS_PAT_END, 32'h5);
      bus(1'b1, OFS_PAT_WADDR, 32'h0);
      for (int i = 0; i < 6; i++) bus(1'b1, OFS_PAT_WDATA, {16'h0, mem_m[i]});
      bus(1'b1, OFS_CTRL, 32'h1);
      n = 0;
      while (user_bits !== 8'hFE && n < 50) begin
         @(negedge hclk);
         n++;
      end
      a = 0;
      for (int k = 0; k < 20; k++) begin
         eo = {{8{~mem_m[a][12] & ~mem_m[a][14]}}, {8{~mem_m[a][12] & ~mem_m[a][15]}}};
         chk("user_bits", {24'h0, user_bits}, {24'h0, mem_m[a][7:0]});
         chk("user_oe", {24'h0, user_bits_oe}, {24'h0, {8{~mem_m[a][13]}}});
         chk("fast_out", {31'h0, fast_output_line}, {31'h0, mem_m[a][11]});
         chk("data_oe", {16'h0, data_oe}, {16'h0, eo});
         a = (a == 5) ? 2 : a + 1;
         @(negedge hclk);
      end
      chk("data_out", {16'h0, data_out}, 32'h0000A55A);
      bus(1'b1, OFS_CTRL, 32'h0);
      // Capture run: latency 2, one settle loop, one measure loop of 4
      // Word 2 raises the upper byte strobe, idle in input mode, used later in byte mode
      for (int i = 0; i < 8; i++)
         mem_m[i] = (i == 0) ? 16'h0001 : (i == 2) ? 16'h4000 : (i == 4) ? 16'h0400 : 16'h0;
      for (int i = 0; i < 12; i++) bus(1'b1, wa[i], {24'h0, wv[i]});
      bus(1'b1, OFS_PAT_WADDR, 32'h0);
      for (int i = 0; i < 8; i++) bus(1'b1, OFS_PAT_WDATA, {16'h0, mem_m[i]});
      lat = 2;
      stl = 1;
      mea = 1;
      a = 0;
      for (n = 1; mea > 0; n++) begin
         if (lat > 0) lat--;
         else begin
            if (stl == 0) exp_q.push_back(n);
            if (a == 3) begin
               a = 0;
               if (stl > 0) stl--;
               else mea--;
            end else a++;
         end
      end
      base = conv_n;
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (3) @(negedge hclk);
      chk("ready_busy", {31'h0, ready_oe}, 32'h1);
      chk("ready_low", {30'h0, hresp, ready_out}, 32'h0);
      a = 0;
      do begin
         bus(1'b0, OFS_STATUS, 32'h0);
         a++;
      end while (rd[1] !== 1'b1 && a < 300);
      // Let the last conversion pulse be counted before comparing
      @(negedge hclk);
      chk("ready_free", {31'h0, ready_oe}, 32'h0);
      chk("conv_starts", conv_n - base, n - 1);
      bus(1'b0, OFS_CAP_ADDR, 32'h0);
      chk("cap_addr", rd, 32'h0);
      foreach (exp_q[k]) begin
         bus(1'b1, OFS_CAP_RADDR, k);
         repeat (2) @(posedge hclk);
         bus(1'b0, OFS_CAP_RDATA, 32'h0);
         chk("cap_data", rd, exp_q[k]);
      end
      // Byte-wise output: upper stimulus byte lands in the low output byte
      bus(1'b1, OFS_IOMODE, 32'h3);
      repeat (40) @(negedge hclk);
      chk("byte_out", {16'h0, data_out}, 32'h0000A5A5);
      chk("byte_oe", {16'h0, data_oe}, 32'h000000FF);
      close_out();
   end
endmodule : psq_top_tb
